/* apdr_pkg.sv */
package apdr_pkg;

   // Register indices on the plain register port
   localparam logic [2:0] REG_POWER_MODE_A = 3'h0;
   localparam logic [2:0] REG_PLD_GATING   = 3'h1;
   localparam logic [2:0] REG_CONFIG       = 3'h2;
   localparam logic [2:0] REG_STATUS       = 3'h3;
   localparam logic [2:0] REG_MEMORY_MAP   = 3'h4;

   // Reset values
   localparam logic [7:0] POWER_MODE_A_RST = 8'h00;
   localparam logic [7:0] PLD_GATING_RST   = 8'h00;
   localparam logic [7:0] CONFIG_RST       = 8'h00;
   localparam logic [7:0] READ_IDLE        = 8'h00;

   // power_mode_control_a fields
   localparam int PMA_AUTO_POWER_DOWN = 1;
   localparam int PMA_FAST_MODE_OFF   = 3;
   localparam int PMA_CLOCK_OFF       = 4;

   // pld_input_gating_control fields
   localparam int GATE_LOW_ADDR  = 0;
   localparam int GATE_CONTROL_0 = 2;
   localparam int GATE_STROBE    = 5;
   localparam int GATE_BYTE_EN   = 6;

   // Configuration register fields
   localparam int CFG_STROBE_POLARITY = 0;

   // Status register fields
   localparam int STAT_POWER_DOWN   = 0;
   localparam int STAT_IN_RESET     = 1;
   localparam int STAT_FLASH_READ   = 2;
   localparam int STAT_ABORTING     = 3;
   localparam int STAT_IDLE_CNT_LSB = 4;

   // Memory map mode register fields
   localparam int MMAP_CODE_SPACE_BIT = 0;

   // Idle counter
   localparam int         IDLE_W     = 4;
   localparam logic [3:0] IDLE_ZERO  = 4'h0;
   localparam logic [3:0] IDLE_LIMIT = 4'hf;
   localparam logic [3:0] IDLE_ONE   = 4'h1;

   // Timing
   localparam int CLK_PERIOD_NS         = 5;
   localparam int POWER_ON_RESET_WIDTH_US = 1;
   localparam int WARM_RESET_WIDTH_NS   = 150;
   localparam int RESET_RECOVERY_TIME_NS = 120;
   localparam int RECOVERY_CYCLES       = RESET_RECOVERY_TIME_NS / CLK_PERIOD_NS;
   localparam int REC_W                 = 6;
   localparam int FLASH_ABORT_TIME_US   = 25;
   localparam int FLASH_ABORT_CYCLES    = FLASH_ABORT_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int ABORT_W               = 16;

endpackage : apdr_pkg

/* apdr_top.sv */
// Chosen here: the plain register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module apdr_top
   import apdr_pkg::*;
#(
   parameter int         ABORT_CYCLES = apdr_pkg::FLASH_ABORT_CYCLES,
   parameter logic [7:0] MMAP_INIT    = 8'h00
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   input  wire logic       addr_strobe,
   input  wire logic       pld_clock_input,
   input  wire logic       chip_select_n,
   input  wire logic       reset_n,
   input  wire logic       flash_busy,
   input  wire logic [7:0] low_addr_in,
   input  wire logic [2:0] control_inputs_0_to_2,
   input  wire logic       data_byte_enable,
   input  wire logic [7:0] mcu_io_oe_req,
   input  wire logic       data_port_oe_req,
   input  wire logic       periph_io_oe_req,
   input  wire logic       addr_out_oe_req,
   output var  logic       power_down_flag,
   output var  logic       mem_select_enable,
   output var  logic       bus_pass_enable,
   output var  logic       pld_fast_mode,
   output var  logic       pld_array_clock,
   output var  logic [7:0] pld_array_low_addr,
   output var  logic [2:0] pld_array_control,
   output var  logic       pld_array_strobe,
   output var  logic       pld_array_byte_enable,
   output var  logic [7:0] mcu_io_oe,
   output var  logic       data_port_oe,
   output var  logic       periph_io_oe,
   output var  logic       addr_out_oe,
   output var  logic       pld_out_valid,
   output var  logic       device_in_reset,
   output var  logic       flash_read_mode,
   output var  logic       flash_abort
);

   import apdr_pkg::*;

   localparam logic [ABORT_W-1:0] ABORT_LOAD = ABORT_W'(ABORT_CYCLES);
   localparam logic [ABORT_W-1:0] ABORT_ONE  = ABORT_W'(1);
   localparam logic [ABORT_W-1:0] ABORT_ZERO = ABORT_W'(0);
   localparam logic [REC_W-1:0]   REC_LOAD   = REC_W'(RECOVERY_CYCLES);
   localparam logic [REC_W-1:0]   REC_ONE    = REC_W'(1);
   localparam logic [REC_W-1:0]   REC_ZERO   = REC_W'(0);
   localparam logic [7:0]         MMAP_RST   = MMAP_INIT & ~(8'h01 << MMAP_CODE_SPACE_BIT);

   logic [7:0]         power_mode_control_a;
   logic [7:0]         pld_input_gating_control;
   logic [7:0]         config_reg;
   logic [7:0]         memory_map_mode_register;
   logic [IDLE_W-1:0]  idle_cnt;
   logic [REC_W-1:0]   rec_cnt;
   logic [ABORT_W-1:0] abort_cnt;
   logic               strobe_q;
   logic               pld_clk_q;
   logic               csi_n_q;
   logic               reset_n_q;
   logic               pd_state;

   logic               auto_power_down;
   logic               strobe_edge;
   logic               clk_rise;
   logic               wake;
   logic               count_step;
   logic               warm_reset;
   logic [REC_W-1:0]   next_rec_cnt;
   logic [ABORT_W-1:0] next_abort_cnt;
   logic               next_pd;
   logic [IDLE_W-1:0]  next_idle_cnt;
   logic               next_in_reset;
   logic [7:0]         status_word;

   ////////////////////////////////////////////////////////////////////////////
   // Event detection on the pins

   always_ff @(posedge clk) begin
      if (srst) begin
         strobe_q  <= 1'b0;
         pld_clk_q <= 1'b0;
         csi_n_q   <= 1'b1;
         reset_n_q <= 1'b0;
      end else if (ce) begin
         strobe_q  <= addr_strobe;
         pld_clk_q <= pld_clock_input;
         csi_n_q   <= chip_select_n;
         reset_n_q <= reset_n;
      end
   end

   always_comb begin
      auto_power_down = power_mode_control_a[PMA_AUTO_POWER_DOWN];
      warm_reset      = ~reset_n;
      strobe_edge     = addr_strobe ^ strobe_q;
      // Raw pin clock, never the gated array clock, so gating cannot stall the count
      clk_rise        = pld_clock_input & ~pld_clk_q;
      wake            = strobe_edge | (~chip_select_n & csi_n_q) | (reset_n & ~reset_n_q);
      count_step      = auto_power_down & ~strobe_edge & clk_rise
                        & (addr_strobe == config_reg[CFG_STROBE_POLARITY])
                        & (idle_cnt != IDLE_LIMIT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle counter and power-down flag

   always_comb begin
      next_idle_cnt = idle_cnt;
      next_pd       = pd_state;
      if (!auto_power_down) begin
         next_idle_cnt = IDLE_ZERO;
         next_pd       = 1'b0;
      end else if (wake) begin
         next_idle_cnt = IDLE_ZERO;
         next_pd       = 1'b0;
      end else if (count_step) begin
         next_idle_cnt = idle_cnt + IDLE_ONE;
         if (idle_cnt == IDLE_LIMIT - IDLE_ONE) begin
            next_pd = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         idle_cnt <= IDLE_ZERO;
         pd_state <= 1'b0;
      end else if (ce) begin
         idle_cnt <= next_idle_cnt;
         pd_state <= next_pd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset recovery and flash abort

   always_comb begin
      next_rec_cnt = rec_cnt;
      if (warm_reset) begin
         next_rec_cnt = REC_LOAD;
      end else if (rec_cnt != REC_ZERO) begin
         next_rec_cnt = rec_cnt - REC_ONE;
      end
      next_in_reset = warm_reset | (next_rec_cnt != REC_ZERO);
      next_abort_cnt = abort_cnt;
      if (abort_cnt != ABORT_ZERO) begin
         next_abort_cnt = abort_cnt - ABORT_ONE;
      end else if (warm_reset && flash_busy) begin
         next_abort_cnt = ABORT_LOAD;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rec_cnt         <= REC_LOAD;
         device_in_reset <= 1'b1;
         abort_cnt       <= ABORT_ZERO;
         flash_abort     <= 1'b0;
         flash_read_mode <= 1'b1;
      end else if (ce) begin
         rec_cnt         <= next_rec_cnt;
         device_in_reset <= next_in_reset;
         abort_cnt       <= next_abort_cnt;
         flash_abort     <= next_abort_cnt != ABORT_ZERO;
         flash_read_mode <= (next_abort_cnt == ABORT_ZERO) & ~flash_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   // Power-mode registers survive warm reset and power down; only power-up clears them
   always_ff @(posedge clk) begin
      if (srst) begin
         power_mode_control_a     <= POWER_MODE_A_RST;
         pld_input_gating_control <= PLD_GATING_RST;
      end else if (ce && reg_wr) begin
         if (reg_addr == REG_POWER_MODE_A) begin
            power_mode_control_a <= reg_wdata;
         end else if (reg_addr == REG_PLD_GATING) begin
            pld_input_gating_control <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         config_reg               <= CONFIG_RST;
         memory_map_mode_register <= MMAP_RST;
      end else if (ce) begin
         if (warm_reset) begin
            config_reg               <= CONFIG_RST;
            memory_map_mode_register <= MMAP_RST;
         end else if (reg_wr && reg_addr == REG_CONFIG) begin
            config_reg <= reg_wdata;
         end else if (reg_wr && reg_addr == REG_MEMORY_MAP) begin
            memory_map_mode_register <= reg_wdata;
         end
      end
   end

   always_comb begin
      status_word                                  = READ_IDLE;
      status_word[STAT_POWER_DOWN]                 = pd_state;
      status_word[STAT_IN_RESET]                   = device_in_reset;
      status_word[STAT_FLASH_READ]                 = flash_read_mode;
      status_word[STAT_ABORTING]                   = flash_abort;
      status_word[STAT_IDLE_CNT_LSB +: IDLE_W]     = idle_cnt;
   end

   // Read data stand for one cycle only; unmapped indices read as zero
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= READ_IDLE;
      end else if (ce) begin
         reg_rdata <= READ_IDLE;
         if (reg_rd) begin
            if (reg_addr == REG_POWER_MODE_A) begin
               reg_rdata <= power_mode_control_a;
            end else if (reg_addr == REG_PLD_GATING) begin
               reg_rdata <= pld_input_gating_control;
            end else if (reg_addr == REG_CONFIG) begin
               reg_rdata <= config_reg;
            end else if (reg_addr == REG_STATUS) begin
               reg_rdata <= status_word;
            end else if (reg_addr == REG_MEMORY_MAP) begin
               reg_rdata <= memory_map_mode_register;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory selection and PLD input gating

   always_ff @(posedge clk) begin
      if (srst) begin
         power_down_flag       <= 1'b0;
         mem_select_enable     <= 1'b0;
         bus_pass_enable       <= 1'b0;
         pld_fast_mode         <= 1'b1;
         pld_array_clock       <= 1'b0;
         pld_array_low_addr    <= 8'h00;
         pld_array_strobe      <= 1'b0;
         pld_array_byte_enable <= 1'b0;
      end else if (ce) begin
         power_down_flag       <= next_pd;
         bus_pass_enable       <= ~next_pd;
         mem_select_enable     <= ~next_pd & ~chip_select_n & ~next_in_reset;
         pld_fast_mode         <= ~power_mode_control_a[PMA_FAST_MODE_OFF];
         pld_array_clock       <= pld_clock_input & ~power_mode_control_a[PMA_CLOCK_OFF];
         pld_array_low_addr    <= (next_pd | pld_input_gating_control[GATE_LOW_ADDR])
                                  ? 8'h00 : low_addr_in;
         pld_array_strobe      <= addr_strobe & ~next_pd
                                  & ~pld_input_gating_control[GATE_STROBE];
         pld_array_byte_enable <= data_byte_enable & ~next_pd
                                  & ~pld_input_gating_control[GATE_BYTE_EN];
      end
   end

   for (genvar i = 0; i < 3; i++) begin : g_control_gate
      always_ff @(posedge clk) begin
         if (srst) begin
            pld_array_control[i] <= 1'b0;
         end else if (ce) begin
            pld_array_control[i] <= control_inputs_0_to_2[i] & ~next_pd
                                    & ~pld_input_gating_control[GATE_CONTROL_0 + i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive control

   always_ff @(posedge clk) begin
      if (srst) begin
         mcu_io_oe     <= 8'h00;
         data_port_oe  <= 1'b0;
         periph_io_oe  <= 1'b0;
         addr_out_oe   <= 1'b0;
         pld_out_valid <= 1'b0;
      end else if (ce) begin
         pld_out_valid <= 1'b1;
         if (next_in_reset) begin
            mcu_io_oe    <= 8'h00;
            data_port_oe <= 1'b0;
            periph_io_oe <= 1'b0;
            addr_out_oe  <= 1'b0;
         end else if (next_pd) begin
            data_port_oe <= 1'b0;
            periph_io_oe <= 1'b0;
            // Address output is undefined here; floating it is the cheapest choice
            addr_out_oe  <= 1'b0;
         end else begin
            mcu_io_oe    <= mcu_io_oe_req;
            data_port_oe <= data_port_oe_req;
            periph_io_oe <= periph_io_oe_req;
            addr_out_oe  <= addr_out_oe_req;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_enter_pd;
      @(posedge clk) disable iff (srst)
      ce && auto_power_down && !wake && count_step && idle_cnt == 4'he |=> power_down_flag && idle_cnt == 4'hf;
   endproperty
   a_enter_pd: assert property (p_enter_pd) else $error("power down not entered after idle count");

   property p_wake;
      @(posedge clk) disable iff (srst)
      ce && power_down_flag && strobe_edge |=> !power_down_flag && idle_cnt == 4'h0;
   endproperty
   a_wake: assert property (p_wake) else $error("strobe pulse did not end power down");

   property p_block;
      @(posedge clk) disable iff (srst)
      power_down_flag |-> !mem_select_enable && !bus_pass_enable && pld_array_low_addr == 8'h00;
   endproperty
   a_block: assert property (p_block) else $error("bus not blocked in power down");

   property p_disabled;
      @(posedge clk) disable iff (srst)
      ce && !auto_power_down |=> idle_cnt == 4'h0 && !power_down_flag;
   endproperty
   a_disabled: assert property (p_disabled) else $error("idle counter ran while disabled");

   property p_keep_pmr;
      @(posedge clk) disable iff (srst)
      ce && !reg_wr && warm_reset |=> power_mode_control_a == $past(power_mode_control_a);
   endproperty
   a_keep_pmr: assert property (p_keep_pmr) else $error("power mode register changed in reset");

   property p_chip_select;
      @(posedge clk) disable iff (srst)
      ce && chip_select_n |=> !mem_select_enable;
   endproperty
   a_chip_select: assert property (p_chip_select) else $error("memories selected with chip select high");

   property p_recovery;
      @(posedge clk) disable iff (srst)
      ce && reset_n && !reset_n_q |=> device_in_reset;
   endproperty
   a_recovery: assert property (p_recovery) else $error("reset recovery too short");

   property p_warm_clear;
      @(posedge clk) disable iff (srst)
      ce && warm_reset |=> config_reg == 8'h00 && !memory_map_mode_register[MMAP_CODE_SPACE_BIT]
                           && mcu_io_oe == 8'h00 && !data_port_oe;
   endproperty
   a_warm_clear: assert property (p_warm_clear) else $error("registers or pins not reset");

   property p_abort;
      @(posedge clk) disable iff (srst)
      ce && abort_cnt == 16'h0001 && !flash_busy |=> flash_read_mode && !flash_abort;
   endproperty
   a_abort: assert property (p_abort) else $error("flash not back in read mode after abort");

endmodule : apdr_top

`default_nettype wire

/* apdr_mcu_model.sv */
`timescale 1ns/10ps
`default_nettype none

module apdr_mcu_model (
   input  wire logic clk,
   input  wire logic run_clock,
   input  wire logic pulse,
   output var  logic addr_strobe,
   output var  logic pld_clock_input
);
   logic div;
   initial begin
      div = 1'b0;
      addr_strobe = 1'b0;
      pld_clock_input = 1'b0;
   end
   // Clock pin stands still while the MCU sleeps, four cycles a period when running
   always @(posedge clk) begin
      if (run_clock) begin
         div <= ~div;
         if (div) pld_clock_input <= ~pld_clock_input;
      end
      if (pulse) addr_strobe <= ~addr_strobe;
   end
endmodule : apdr_mcu_model

`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import apdr_pkg::*;
   localparam int ABORT = 20;
   logic            clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0, chip_select_n = 0, reset_n = 1;
   logic            flash_busy = 0, data_byte_enable = 0, run_clock = 0, pulse = 0;
   logic            data_port_oe_req = 0, periph_io_oe_req = 0, addr_out_oe_req = 0;
   logic [2:0]      reg_addr = 0, control_inputs_0_to_2 = 0;
   logic [7:0]      reg_wdata = 0, low_addr_in = 0, mcu_io_oe_req = 0;
   wire logic [7:0] reg_rdata, pld_array_low_addr, mcu_io_oe;
   wire logic [2:0] pld_array_control;
   wire logic       addr_strobe, pld_clock_input, power_down_flag, mem_select_enable, bus_pass_enable;
   wire logic       pld_fast_mode, pld_array_clock, pld_array_strobe, pld_array_byte_enable, data_port_oe;
   wire logic       periph_io_oe, addr_out_oe, pld_out_valid, device_in_reset, flash_read_mode, flash_abort;
   int              err_count = 0, checked = 0, n, model_reg [0:4];
   integer          seed = 14;

   apdr_top #(.ABORT_CYCLES(ABORT)) apdr_top_inst (
      .clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_strobe(addr_strobe), .pld_clock_input(pld_clock_input),
      .chip_select_n(chip_select_n), .reset_n(reset_n), .flash_busy(flash_busy), .low_addr_in(low_addr_in),
      .control_inputs_0_to_2(control_inputs_0_to_2), .data_byte_enable(data_byte_enable),
      .mcu_io_oe_req(mcu_io_oe_req), .data_port_oe_req(data_port_oe_req), .periph_io_oe_req(periph_io_oe_req),
      .addr_out_oe_req(addr_out_oe_req), .power_down_flag(power_down_flag), .mem_select_enable(mem_select_enable),
      .bus_pass_enable(bus_pass_enable), .pld_fast_mode(pld_fast_mode), .pld_array_clock(pld_array_clock),
      .pld_array_low_addr(pld_array_low_addr), .pld_array_control(pld_array_control),
      .pld_array_strobe(pld_array_strobe), .pld_array_byte_enable(pld_array_byte_enable), .mcu_io_oe(mcu_io_oe),
      .data_port_oe(data_port_oe), .periph_io_oe(periph_io_oe), .addr_out_oe(addr_out_oe),
      .pld_out_valid(pld_out_valid), .device_in_reset(device_in_reset), .flash_read_mode(flash_read_mode),
      .flash_abort(flash_abort));
   apdr_mcu_model apdr_mcu_model_inst (.clk(clk), .run_clock(run_clock), .pulse(pulse),
      .addr_strobe(addr_strobe), .pld_clock_input(pld_clock_input));

   always #2.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 0;
      if (a < 5 && a != 3) model_reg[a] = d;
   endtask : wr

   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1; reg_addr <= a;
      @(posedge clk);
      reg_rd <= 0;
      #1 chk(reg_rdata, exp, "read");
   endtask : rdc

   task automatic conclude;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      err_count++;
      conclude();
   end

   initial begin
      model_reg = '{default: 0};
      repeat (3) @(posedge clk);
      // Power-up reset far shorter than on silicon; register strobes stay low throughout it
      srst <= 0;
      repeat (30) @(posedge clk);
      rdc(0, 0);
      rdc(1, 0);
      rdc(5, 0);
      chk(mem_select_enable, 1, "mem enable");
      chk(pld_fast_mode, 1, "fast mode");
      @(posedge clk) chip_select_n <= 1;
      repeat (2) @(posedge clk);
      #1 chk(mem_select_enable, 0, "mem disable");
      @(posedge clk) chip_select_n <= 0;
      // Strobe high so that its gating bit has something to cut
      pulse <= 1;
      @(posedge clk) pulse <= 0;
      // Each gating bit alone, random array inputs behind it
      for (n = 0; n < 7; n++) if (n != 1) begin
         wr(1, 8'h01 << n);
         low_addr_in <= 8'($random(seed));
         control_inputs_0_to_2 <= 3'($random(seed));
         data_byte_enable <= 1'($random(seed));
         repeat (3) @(posedge clk);
         #1 chk(pld_array_low_addr, model_reg[1][0] ? 8'h00 : low_addr_in, "low addr");
         chk(pld_array_control, control_inputs_0_to_2 & ~model_reg[1][4:2], "control");
         chk(pld_array_strobe, addr_strobe & ~model_reg[1][5], "strobe");
         chk(pld_array_byte_enable, data_byte_enable & ~model_reg[1][6], "byte en");
      end
      wr(1, 8'h00);
      // Auto power down with the array clock cut and fast mode off, strobe idle high
      data_port_oe_req <= 1;
      periph_io_oe_req <= 1;
      addr_out_oe_req <= 1;
      wr(2, 8'h01);
      wr(0, 8'h3a);
      @(posedge clk) run_clock <= 1;
      repeat (14) @(posedge pld_clock_input);
      repeat (3) @(posedge clk);
      #1 chk(power_down_flag, 0, "early flag");
      chk(pld_array_clock, 0, "array clock");
      chk(pld_fast_mode, 0, "fast off");
      chk({data_port_oe, periph_io_oe, addr_out_oe}, 8'h07, "ports drive");
      @(posedge pld_clock_input);
      repeat (3) @(posedge clk);
      #1 chk(power_down_flag, 1, "flag");
      chk(bus_pass_enable, 0, "bus block");
      chk(mem_select_enable, 0, "mem desel");
      chk({data_port_oe, periph_io_oe, addr_out_oe}, 8'h00, "ports float");
      rdc(3, 8'hf5);
      // Clock enable low freezes the flag although the strobe moves
      @(posedge clk) ce <= 0;
      pulse <= 1;
      @(posedge clk) pulse <= 0;
      run_clock <= 0;
      repeat (2) @(posedge clk);
      #1 chk(power_down_flag, 1, "frozen");
      @(posedge clk) ce <= 1;
      repeat (2) @(posedge clk);
      #1 chk(power_down_flag, 0, "wake");
      chk(bus_pass_enable, 1, "bus pass");
      // Warm reset during a flash operation
      wr(0, 8'h22);
      wr(2, 8'h01);
      wr(4, 8'h5b);
      @(posedge clk);
      reset_n <= 0; flash_busy <= 1; mcu_io_oe_req <= 8'hff;
      repeat (2) @(posedge clk);
      #1 chk(device_in_reset, 1, "in reset");
      chk(flash_abort, 1, "abort");
      chk(mcu_io_oe, 0, "io input");
      chk(pld_out_valid, 1, "pld valid");
      // Flash side ends its operation once aborted, so no second abort follows
      @(posedge clk) flash_busy <= 0;
      // Two abort cycles already counted before this look
      #1 n = 2;
      while (flash_abort === 1'b1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      chk(n, ABORT, "abort length");
      @(posedge clk);
      repeat (3) @(posedge clk);
      #1 chk(flash_read_mode, 1, "read mode");
      // Pulse kept well over 150 ns
      repeat (10) @(posedge clk);
      reset_n <= 1;
      repeat (20) @(posedge clk);
      #1 chk(device_in_reset, 1, "recovery");
      repeat (10) @(posedge clk);
      #1 chk(device_in_reset, 0, "recovered");
      chk(mcu_io_oe, 8'hff, "io drive");
      rdc(0, model_reg[0]);
      rdc(2, 0);
      rdc(4, 8'h00);
      conclude();
   end
endmodule : testbench

`default_nettype wire
